// File: shared/twbpe_consts.svh
// How it works
// (RL1) Lines are only pulled low or released, never driven high.
// (RL2) SDA changes only while SCL is low, except for START and STOP.
// (RL3) START is SDA falling and STOP is SDA rising while SCL is high.
// (RL4) Bus is busy from START to STOP; no new transfer starts while busy.
// (RL5) Repeated START keeps ownership; bus stays busy until a STOP.
// (RL6) Address packet: seven address bits MSB first, direction bit, ack bit.
// (RL7) Direction bit one means read, zero means write.
// (RL8) Addressed slave acks by pulling SDA low in the ninth cycle.
// (RL9) After an address not-acknowledge the master sends STOP or repeated START.
// (RL10) Address zero is the general call, never an individual slave.
// (RL11) General call with write is acked by enabled slaves, then data follows.
// (RL12) General call address is never sent with the read direction.
// (RL13) Addresses with upper four bits all ones stay reserved.
// (RL14) Data packet: eight data bits MSB first, then receiver ack bit.
// (RL15) Master alone makes SCL and the START and STOP conditions.
// (RL16) SDA low in the ninth cycle is ack; released SDA is not-ack.
// (RL17) Receiver answers its final wanted byte with a not-acknowledge.
// (RL18) Transfer is START, address, one or more data bytes, STOP.
// (RL19) Slave may hold SCL low; master waits until SCL is seen high.
// (RL20) Phase timing starts when the real SCL level is seen to change.
// (RL21) After reset or STOP both lines are released and bus is idle.
// (RL22) SCL and SDA are synchronised before any logic reads them.
`ifndef TWBPE_CONSTS_SVH
`define TWBPE_CONSTS_SVH

// ==========================================
// timing
`define TWBPE_CLK_NS 8
`define TWBPE_HALF_NS 1250
`define TWBPE_HALF_CYC ((`TWBPE_HALF_NS + `TWBPE_CLK_NS - 1) / `TWBPE_CLK_NS)

// ==========================================
// packet layout
`define TWBPE_RW_BIT 4'h7
`define TWBPE_ACK_BIT 4'h8
`define TWBPE_GC_ADDR 7'h00
`define TWBPE_RSV_TOP 4'hF
`define TWBPE_LEN_W 8

// ==========================================
// reset values
`define TWBPE_LINE_IDLE 1'b1
`define TWBPE_OE_OFF 1'b0

`endif

// File: shared/twbpe_pkg.sv
package twbpe_pkg;

   // ==========================================
   // bit engine states
   typedef enum logic [6:0] {
      TWBPE_IDLE = 7'h01,
      TWBPE_START = 7'h02,
      TWBPE_LOW = 7'h04,
      TWBPE_RISE = 7'h08,
      TWBPE_HIGH = 7'h10,
      TWBPE_STOP = 7'h20,
      TWBPE_OWN = 7'h40
   } twbpe_state_t;

   // ==========================================
   // what the current clock pulse carries
   typedef enum logic [3:0] {
      TWBPE_K_ADDR = 4'h1,
      TWBPE_K_DATA = 4'h2,
      TWBPE_K_STOP = 4'h4,
      TWBPE_K_RSTART = 4'h8
   } twbpe_kind_t;

endpackage

// File: rtl/twbpe_sync.sv
`timescale 1ns/1ns
`include "twbpe_consts.svh"

module twbpe_sync #(
   parameter int W = 2
) (
   input logic clk,
   input logic rst_n,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   // lines idle high, so reset to released
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= {W{`TWBPE_LINE_IDLE}};
         q <= {W{`TWBPE_LINE_IDLE}};
      end else begin
         meta <= d; // RL22
         q <= meta; // RL22
      end
   end
endmodule // twbpe_sync

// File: rtl/twbpe_cond.sv
`timescale 1ns/1ns
`include "twbpe_consts.svh"

module twbpe_cond (
   input logic clk,
   input logic rst_n,
   input logic scl,
   input logic sda,
   output logic busy
);
   logic scl_d;
   logic sda_d;
   logic start_seen;
   logic stop_seen;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_d <= `TWBPE_LINE_IDLE;
         sda_d <= `TWBPE_LINE_IDLE;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // scl high on both samples so a clock edge is not taken for a condition
   assign start_seen = scl && scl_d && sda_d && !sda; // RL3
   assign stop_seen = scl && scl_d && !sda_d && sda; // RL3

   // ==========================================
   // bus occupancy, sees every master including us
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy <= 1'b0; // RL21
      end else if (start_seen) begin
         busy <= 1'b1; // RL4
      end else if (stop_seen) begin
         busy <= 1'b0; // RL21
      end
   end
endmodule // twbpe_cond

// File: rtl/twbpe_master.sv
`timescale 1ns/1ns
`include "twbpe_consts.svh"

module twbpe_master #(
   parameter int HALF_CYC = `TWBPE_HALF_CYC,
   parameter int LEN_W = `TWBPE_LEN_W
) (
   input logic SYS_CLK,
   input logic RST_N,
   input logic REQ_VALID,
   output logic REQ_READY,
   input logic [6:0] REQ_ADDR,
   input logic REQ_READ,
   input logic [LEN_W-1:0] REQ_LEN,
   input logic REQ_HOLD,
   input logic WR_VALID,
   output logic WR_READY,
   input logic [7:0] WR_DATA,
   output logic RD_VALID,
   output logic [7:0] RD_DATA,
   output logic DONE,
   output logic ERR,
   output logic BUS_BUSY,
   input logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE,
   input logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE
);
   import twbpe_pkg::*;

   localparam logic [15:0] HALF = 16'(HALF_CYC);

   // ==========================================
   // line sampling and bus watch
   logic [1:0] lines_s;
   logic scl_s;
   logic sda_s;
   logic busy;

   twbpe_sync #(
      .W(2)
   ) u_sync (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .d({SCL_I, SDA_I}),
      .q(lines_s)
   );

   assign scl_s = lines_s[1];
   assign sda_s = lines_s[0];

   twbpe_cond u_cond (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .scl(scl_s),
      .sda(sda_s),
      .busy(busy)
   );

   // ==========================================
   // state
   twbpe_state_t st;
   twbpe_kind_t kind;
   logic [15:0] cnt;
   logic [3:0] bit_cnt;
   logic [8:0] sh;
   logic [7:0] rx;
   logic [LEN_W-1:0] left;
   logic [6:0] addr;
   logic rd;
   logic hold;
   logic sda_set;
   logic scl_oe;
   logic sda_oe;
   logic err_acc;

   // requests that must never reach the bus
   function automatic logic refuse(input logic [6:0] a, input logic r,
                                   input logic [LEN_W-1:0] n);
      refuse = (a == `TWBPE_GC_ADDR && r) // RL10
         || a[6:3] == `TWBPE_RSV_TOP // RL13
         || n == '0; // RL18
   endfunction

   // ==========================================
   // decode
   logic take;
   logic req_bad;
   logic go_start;
   logic go_rs;
   logic drop_own;
   logic need_byte;
   logic set_bit;
   logic low_end;
   logic high_end;
   logic frame_end;
   logic nacked;
   logic last;
   logic to_stop;
   logic to_own;
   logic nack_err;
   logic out_bit;
   logic stop_end;

   // idle lines needed too, a stretched clock would spoil the start
   assign REQ_READY = (st == TWBPE_IDLE && !busy && scl_s && sda_s)
      || st == TWBPE_OWN; // RL4
   assign take = REQ_VALID && REQ_READY;
   assign req_bad = refuse(REQ_ADDR, REQ_READ, REQ_LEN); // RL12
   assign go_start = take && !req_bad && st == TWBPE_IDLE;
   assign go_rs = take && !req_bad && st == TWBPE_OWN; // RL5
   assign drop_own = take && req_bad && st == TWBPE_OWN;

   assign need_byte = kind == TWBPE_K_DATA && !rd && bit_cnt == 4'h0;
   // scl is held low while the write byte is late: stall, not corrupt
   assign set_bit = st == TWBPE_LOW && !scl_s && !sda_set
      && (!need_byte || WR_VALID); // RL20
   assign WR_READY = st == TWBPE_LOW && !scl_s && !sda_set && need_byte;
   assign low_end = st == TWBPE_LOW && sda_set && cnt == '0;
   assign high_end = st == TWBPE_HIGH && cnt == '0;

   assign frame_end = high_end && bit_cnt == `TWBPE_ACK_BIT
      && (kind == TWBPE_K_ADDR || kind == TWBPE_K_DATA); // RL14
   assign nacked = sda_s; // RL16
   assign last = left == LEN_W'(1);
   // general call write is acked like any address and goes on to data
   assign to_stop = frame_end && (kind == TWBPE_K_ADDR ? nacked
      : ((!rd && nacked && !last) || (last && !hold))); // RL9 RL11
   assign to_own = frame_end && kind == TWBPE_K_DATA && last && hold;
   assign nack_err = frame_end && nacked
      && (kind == TWBPE_K_ADDR || (!rd && !last)); // RL8
   assign stop_end = st == TWBPE_STOP && cnt == '0;

   assign out_bit = (kind == TWBPE_K_STOP) ? 1'b0
      : (kind == TWBPE_K_RSTART) ? 1'b1
      : (kind == TWBPE_K_DATA && bit_cnt == 4'h0) ? (rd | WR_DATA[7])
      : sh[8]; // RL6 RL14

   // ==========================================
   // bit engine
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st <= TWBPE_IDLE;
         cnt <= '0;
         sda_set <= 1'b0;
      end else begin
         unique case (st)
            TWBPE_IDLE: begin
               if (go_start) begin
                  st <= TWBPE_START;
                  cnt <= HALF;
               end
            end
            TWBPE_START: begin
               if (cnt == '0) begin
                  st <= TWBPE_LOW;
                  cnt <= HALF;
                  sda_set <= 1'b0;
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            TWBPE_LOW: begin
               // low time counts only once the line is really low
               if (set_bit) begin
                  sda_set <= 1'b1; // RL20
               end else if (low_end) begin
                  st <= TWBPE_RISE;
               end else if (sda_set) begin
                  cnt <= cnt - 16'h0001;
               end
            end
            TWBPE_RISE: begin
               if (scl_s) begin
                  st <= TWBPE_HIGH; // RL19
                  cnt <= HALF;
               end
            end
            TWBPE_HIGH: begin
               if (!high_end) begin
                  cnt <= cnt - 16'h0001;
               end else if (kind == TWBPE_K_STOP) begin
                  st <= TWBPE_STOP;
                  cnt <= HALF;
               end else if (kind == TWBPE_K_RSTART) begin
                  st <= TWBPE_START; // RL5
                  cnt <= HALF;
               end else if (to_own) begin
                  st <= TWBPE_OWN;
               end else begin
                  st <= TWBPE_LOW;
                  cnt <= HALF;
                  sda_set <= 1'b0;
               end
            end
            TWBPE_STOP: begin
               if (cnt == '0) begin
                  st <= TWBPE_IDLE; // RL21
               end else begin
                  cnt <= cnt - 16'h0001;
               end
            end
            TWBPE_OWN: begin
               if (go_rs || drop_own) begin
                  st <= TWBPE_LOW;
                  cnt <= HALF;
                  sda_set <= 1'b0;
               end
            end
            default: begin
               st <= TWBPE_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // packet path
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         kind <= TWBPE_K_ADDR;
         bit_cnt <= 4'h0;
         sh <= 9'h1FF;
         rx <= 8'h00;
         left <= '0;
         addr <= 7'h00;
         rd <= 1'b0;
         hold <= 1'b0;
      end else if (go_start || go_rs) begin
         addr <= REQ_ADDR;
         rd <= REQ_READ;
         left <= REQ_LEN;
         hold <= REQ_HOLD;
         kind <= go_start ? TWBPE_K_ADDR : TWBPE_K_RSTART;
         bit_cnt <= 4'h0;
         sh <= {REQ_ADDR, REQ_READ, 1'b1}; // RL6 RL7
      end else if (drop_own) begin
         kind <= TWBPE_K_STOP; // RL18
      end else if (set_bit && need_byte) begin
         sh <= {WR_DATA, 1'b1}; // RL14
      end else if (set_bit && kind == TWBPE_K_DATA && bit_cnt == 4'h0) begin
         sh <= {8'hFF, last}; // RL17
      end else if (high_end) begin
         if (kind == TWBPE_K_RSTART) begin
            kind <= TWBPE_K_ADDR;
         end else if (kind != TWBPE_K_STOP) begin
            if (kind == TWBPE_K_DATA && rd && bit_cnt != `TWBPE_ACK_BIT) begin
               rx <= {rx[6:0], sda_s};
            end
            if (frame_end) begin
               bit_cnt <= 4'h0;
               if (kind == TWBPE_K_DATA) begin
                  left <= left - LEN_W'(1);
               end
               kind <= to_stop ? TWBPE_K_STOP : TWBPE_K_DATA; // RL9
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
               sh <= {sh[7:0], 1'b1};
            end
         end
      end
   end

   // ==========================================
   // line drivers, open drain only
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         scl_oe <= `TWBPE_OE_OFF; // RL21
         sda_oe <= `TWBPE_OE_OFF; // RL21
      end else if (go_start) begin
         sda_oe <= 1'b1; // RL3
      end else if (st == TWBPE_START && cnt == '0) begin
         scl_oe <= 1'b1; // RL15
      end else if (set_bit) begin
         sda_oe <= !out_bit; // RL1 RL2
      end else if (low_end) begin
         scl_oe <= 1'b0; // RL15
      end else if (high_end) begin
         if (kind == TWBPE_K_STOP) begin
            sda_oe <= 1'b0; // RL3
         end else if (kind == TWBPE_K_RSTART) begin
            sda_oe <= 1'b1; // RL5
         end else begin
            scl_oe <= 1'b1; // RL15
         end
      end
   end

   assign SCL_OE = scl_oe;
   assign SDA_OE = sda_oe;
   assign SCL_O = 1'b0; // RL1
   assign SDA_O = 1'b0; // RL1
   assign BUS_BUSY = busy;

   // ==========================================
   // user side status
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         DONE <= 1'b0;
         ERR <= 1'b0;
         RD_VALID <= 1'b0;
         RD_DATA <= 8'h00;
         err_acc <= 1'b0;
      end else begin
         DONE <= stop_end || to_own || (take && req_bad && st == TWBPE_IDLE);
         RD_VALID <= high_end && kind == TWBPE_K_DATA && rd
            && bit_cnt == `TWBPE_RW_BIT;
         if (high_end && kind == TWBPE_K_DATA && rd
             && bit_cnt == `TWBPE_RW_BIT) begin
            RD_DATA <= {rx[6:0], sda_s};
         end
         if (take && !req_bad) begin
            err_acc <= 1'b0;
         end else if (nack_err || (take && req_bad)) begin
            err_acc <= 1'b1; // RL8
         end
         if (stop_end || to_own) begin
            ERR <= err_acc;
         end else if (take && req_bad && st == TWBPE_IDLE) begin
            ERR <= 1'b1;
         end
      end
   end

   // ==========================================
   // checks
   a_sda_pulls_low: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      sda_oe [*4] |-> !sda_s) // RL1
      else $error("sda driven yet reads high");

   a_sda_steady_high: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_HIGH && $past(st) == TWBPE_HIGH |-> $stable(sda_oe)) // RL2
      else $error("sda moved during scl high");

   a_start_shape: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $rose(sda_oe) && !scl_oe |-> st == TWBPE_START) // RL3
      else $error("sda fell with scl high outside start");

   a_stop_shape: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $fell(sda_oe) && !scl_oe |-> st == TWBPE_STOP) // RL3
      else $error("sda rose with scl high outside stop");

   a_wait_free_bus: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_START && $past(st) == TWBPE_IDLE |-> !$past(busy)) // RL4
      else $error("start issued on busy bus");

   a_own_stays_busy: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_OWN |-> busy) // RL5
      else $error("bus seen free while owned");

   a_addr_nine_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      frame_end && kind == TWBPE_K_ADDR && !nacked
      |=> kind == TWBPE_K_DATA && bit_cnt == 4'h0) // RL6
      else $error("address packet not nine bits");

   a_dir_bit: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_LOW && sda_set && kind == TWBPE_K_ADDR
      && bit_cnt == `TWBPE_RW_BIT |-> sda_oe == !rd) // RL7
      else $error("direction bit wrong");

   a_nack_stops: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      frame_end && kind == TWBPE_K_ADDR && nacked
      |=> kind == TWBPE_K_STOP ##1 st == TWBPE_LOW) // RL9
      else $error("no stop after address nack");

   a_legal_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_START && $past(st) == TWBPE_IDLE
      |-> !refuse(addr, rd, left)) // RL12
      else $error("illegal request reached bus");

   a_ack_released: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_LOW && sda_set && bit_cnt == `TWBPE_ACK_BIT
      && (kind == TWBPE_K_ADDR || (kind == TWBPE_K_DATA && !rd))
      |-> !sda_oe) // RL16
      else $error("master drove slave ack slot");

   a_last_nack: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_LOW && sda_set && kind == TWBPE_K_DATA && rd
      && bit_cnt == `TWBPE_ACK_BIT |-> sda_oe == !last) // RL17
      else $error("read ack slot wrong");

   a_stretch_wait: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      st == TWBPE_RISE && !scl_s |=> st == TWBPE_RISE) // RL19
      else $error("high phase began while scl held low");

endmodule // twbpe_master

// File: testbench/twbpe_slave_model.sv
`timescale 1ns/1ns

// ==========================================
// behavioural slave on the shared two-wire bus
module twbpe_slave_model #(
   parameter logic [6:0] OWN_ADDR = 7'h2C,
   parameter logic [7:0] RD_BASE = 8'hC3
) (
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   input wire logic [3:0] stretch,
   input wire logic [7:0] nack_at,
   input wire logic gc_en,
   output logic pull_scl,
   output logic pull_sda
);
   logic scl_q = 1'b1, sda_q = 1'b1, fresh = 1'b0, act = 1'b0;
   logic addr_ph = 1'b0, sel = 1'b0, rd = 1'b0, mack = 1'b0;
   logic [3:0] b = 4'h0, hold = 4'h0;
   logic [7:0] sh = 8'h00, cnt = 8'h00, tx = 8'h00, nxt;
   int n_start = 0, n_stop = 0;
   logic [7:0] rx_q[$];
   logic mack_q[$];
   initial begin
      pull_scl = 1'b0;
      pull_sda = 1'b0;
   end
   // only pulls low, never drives high
   always @(posedge clk) begin
      scl_q <= scl;
      sda_q <= sda;
      pull_scl <= (hold != 4'h0);
      if (hold != 4'h0) hold <= hold - 4'h1;
      if (scl && scl_q && sda_q && !sda) begin
         n_start <= n_start + 1;
         {act, fresh, addr_ph, sel} <= 4'b1110;
         b <= 4'h0;
         cnt <= 8'h00;
         pull_sda <= 1'b0;
      end else if (scl && scl_q && !sda_q && sda) begin
         n_stop <= n_stop + 1;
         {act, sel, pull_sda} <= 3'b000;
      end else if (act && scl && !scl_q) begin
         if (b < 4'h8) sh <= {sh[6:0], sda};
         else if (sel && rd && !addr_ph) mack <= !sda;
      end else if (act && !scl && scl_q) begin
         // sda only moves after scl is seen low
         if (stretch != 4'h0) begin
            hold <= stretch;
            pull_scl <= 1'b1;
         end
         if (fresh) begin
            fresh <= 1'b0;
         end else if (b == 4'h7) begin
            b <= 4'h8;
            if (addr_ph) begin
               if (sh[7:1] == OWN_ADDR || (sh[7:1] == 7'h00 && !sh[0] && gc_en)) begin
                  sel <= 1'b1;
                  rd <= sh[0];
                  pull_sda <= 1'b1;
               end
            end else if (sel && !rd) begin
               rx_q.push_back(sh);
               pull_sda <= (cnt != nack_at);
               cnt <= cnt + 8'h01;
            end else begin
               pull_sda <= 1'b0;
            end
         end else if (b == 4'h8) begin
            b <= 4'h0;
            addr_ph <= 1'b0;
            if (sel && rd && !addr_ph) mack_q.push_back(mack);
            if (sel && rd && (addr_ph || mack)) begin
               nxt = RD_BASE + cnt;
               tx <= nxt;
               cnt <= cnt + 8'h01;
               pull_sda <= !nxt[7];
            end else begin
               pull_sda <= 1'b0;
               if (rd && !addr_ph) sel <= 1'b0;
            end
         end else begin
            b <= b + 4'h1;
            pull_sda <= sel && rd && !addr_ph && !tx[6 - b];
         end
      end
   end
endmodule // twbpe_slave_model

// File: testbench/two_wire_bus_protocol_engine_tb_top.sv
`timescale 1ns/1ns

module two_wire_bus_protocol_engine_tb_top;
   logic SYS_CLK, RST_N, REQ_VALID, REQ_READY, REQ_READ, REQ_HOLD;
   logic [6:0] REQ_ADDR;
   logic [7:0] REQ_LEN, WR_DATA, RD_DATA;
   logic WR_VALID, WR_READY, RD_VALID, DONE, ERR, BUS_BUSY;
   logic SCL_O, SCL_OE, SDA_O, SDA_OE, pull_scl, pull_sda;
   logic ext_sda = 1'b0, gc_en = 1'b0, oe_seen = 1'b0, busy_seen = 1'b0;
   logic [3:0] stretch = 4'h0;
   logic [7:0] nack_at = 8'hFF;
   logic [7:0] rd_q[$];
   int n_mismatch = 0, n_checks = 0, n_cyc = 0;
   wire scl_w = !(SCL_OE || pull_scl);
   wire sda_w = !(SDA_OE || pull_sda || ext_sda);

   twbpe_master #(.HALF_CYC(5), .LEN_W(8)) dut (.SYS_CLK(SYS_CLK),
      .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
      .REQ_ADDR(REQ_ADDR), .REQ_READ(REQ_READ), .REQ_LEN(REQ_LEN),
      .REQ_HOLD(REQ_HOLD), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
      .WR_DATA(WR_DATA), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA),
      .DONE(DONE), .ERR(ERR), .BUS_BUSY(BUS_BUSY), .SCL_I(scl_w),
      .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(sda_w), .SDA_O(SDA_O),
      .SDA_OE(SDA_OE));
   twbpe_slave_model slv (.clk(SYS_CLK), .scl(scl_w), .sda(sda_w),
      .stretch(stretch), .nack_at(nack_at), .gc_en(gc_en),
      .pull_scl(pull_scl), .pull_sda(pull_sda));

   // ==========================================
   // clock, monitor and timeout
   initial begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      n_cyc++;
      if (SCL_OE || SDA_OE) oe_seen <= 1'b1;
      if (BUS_BUSY) busy_seen <= 1'b1;
      // ceiling far above the roughly 5000 cycles the scenarios need
      if (n_cyc == 30000) begin
         n_mismatch++;
         close_out();
      end
   end

   // ==========================================
   // shared helpers
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [7:0] wr_byte(input int k);
      return 8'h96 + 8'(k) * 8'h3B;
   endfunction
   task automatic clr();
      oe_seen = 1'b0;
      busy_seen = 1'b0;
      rd_q.delete();
      slv.rx_q.delete();
      slv.mack_q.delete();
   endtask
   // one request, serving write bytes and collecting read bytes
   task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] n,
                       input logic h, output logic e, output int cyc);
      int k;
      k = 0;
      cyc = 0;
      {REQ_ADDR, REQ_READ, REQ_LEN, REQ_HOLD} = {a, r, n, h};
      REQ_VALID = 1'b1;
      while (REQ_READY !== 1'b1 && cyc < 300) begin
         @(negedge SYS_CLK);
         cyc++;
      end
      @(negedge SYS_CLK);
      REQ_VALID = 1'b0;
      cyc = 0;
      while (DONE !== 1'b1 && cyc < 5000) begin
         if (WR_VALID) begin
            WR_VALID = 1'b0;
            k++;
         end else if (WR_READY === 1'b1) begin
            WR_VALID = 1'b1;
            WR_DATA = wr_byte(k);
         end
         if (RD_VALID === 1'b1) rd_q.push_back(RD_DATA);
         if (SCL_OE || SDA_OE) chk("pins_low", {SCL_O, SDA_O}, 0);
         @(negedge SYS_CLK);
         cyc++;
      end
      chk("done_seen", DONE, 1'b1);
      e = ERR;
      // one edge between calls, so valid never toggles twice in one step
      @(negedge SYS_CLK);
   endtask

   // ==========================================
   // scenarios
   task automatic t_write();
      logic e;
      int c, s0, p0;
      clr();
      // longer than the master's own low time, so the wait really happens
      stretch = 4'hF;
      {s0, p0} = {slv.n_start, slv.n_stop};
      xfer(slv.OWN_ADDR, 1'b0, 8'h03, 1'b0, e, c);
      chk("wr_err", e, 1'b0);
      chk("wr_count", slv.rx_q.size(), 3);
      for (int i = 0; i < 3; i++) chk("wr_byte", slv.rx_q[i], wr_byte(i));
      chk("wr_starts", slv.n_start - s0, 1);
      chk("wr_stops", slv.n_stop - p0, 1);
      chk("wr_busy", {busy_seen, BUS_BUSY}, 2'b10);
      stretch = 4'h0;
   endtask
   task automatic t_read(input logic h0);
      logic e;
      int c, s0, p0;
      clr();
      {s0, p0} = {slv.n_start, slv.n_stop};
      if (h0) begin
         xfer(slv.OWN_ADDR, 1'b0, 8'h01, 1'b1, e, c);
         chk("hold_busy", {e, BUS_BUSY}, 2'b01);
         chk("hold_stops", slv.n_stop - p0, 0);
      end
      xfer(slv.OWN_ADDR, 1'b1, 8'h03, 1'b0, e, c);
      chk("rd_err", e, 1'b0);
      chk("rd_count", rd_q.size(), 3);
      for (int i = 0; i < 3; i++) begin
         chk("rd_byte", rd_q[i], slv.RD_BASE + 8'(i));
         chk("rd_ack", slv.mack_q[i], i < 2);
      end
      chk("rd_starts", slv.n_start - s0, h0 ? 2 : 1);
      chk("rd_stops", slv.n_stop - p0, 1);
   endtask
   task automatic t_nack(input logic [6:0] a, input logic [7:0] na,
                         input logic exp);
      logic e;
      int c, p0;
      clr();
      nack_at = na;
      p0 = slv.n_stop;
      xfer(a, 1'b0, 8'h03, 1'b0, e, c);
      chk("nack_err", e, exp);
      chk("nack_stop", {slv.n_stop - p0, BUS_BUSY}, 2);
      nack_at = 8'hFF;
   endtask
   task automatic t_refuse();
      logic [15:0] tab[4] = '{16'h0101, 16'hF001, 16'hFF01, 16'h5800};
      logic e;
      int c, p0;
      for (int i = 0; i < 4; i++) begin
         clr();
         xfer(tab[i][15:9], tab[i][8], tab[i][7:0], 1'b0, e, c);
         chk("ref_err", e, 1'b1);
         chk("ref_fast", c <= 2, 1'b1);
         chk("ref_quiet", oe_seen, 1'b0);
      end
      // refused while the bus is held: released by a stop, then error
      clr();
      xfer(slv.OWN_ADDR, 1'b0, 8'h01, 1'b1, e, c);
      p0 = slv.n_stop;
      xfer(7'h7A, 1'b0, 8'h01, 1'b0, e, c);
      chk("own_drop", {e, BUS_BUSY}, 2'b10);
      chk("own_stop", slv.n_stop - p0, 1);
   endtask
   task automatic t_gcall();
      logic e;
      int c;
      clr();
      gc_en = 1'b1;
      xfer(7'h00, 1'b0, 8'h01, 1'b0, e, c);
      chk("gc_err", e, 1'b0);
      chk("gc_byte", slv.rx_q[0], wr_byte(0));
      gc_en = 1'b0;
   endtask
   task automatic t_busy();
      logic e;
      int c;
      clr();
      ext_sda = 1'b1;
      repeat (6) @(negedge SYS_CLK);
      chk("ext_busy", {BUS_BUSY, REQ_READY}, 2'b10);
      // request held through the foreign transfer, taken only after its stop
      fork
         xfer(7'h00, 1'b1, 8'h01, 1'b0, e, c);
         begin
            repeat (20) @(negedge SYS_CLK);
            chk("ext_quiet", {oe_seen, DONE}, 0);
            ext_sda = 1'b0;
         end
      join
      chk("ext_err", {e, oe_seen}, 2'b10);
      chk("ext_idle", {BUS_BUSY, REQ_READY}, 2'b01);
   endtask

   // ==========================================
   // main sequence
   initial begin
      {RST_N, REQ_VALID, REQ_READ, REQ_HOLD, WR_VALID} = 5'b00000;
      {REQ_ADDR, REQ_LEN, WR_DATA} = 23'h0;
      repeat (3) @(negedge SYS_CLK);
      chk("rst_out", {SCL_OE, SDA_OE, DONE, ERR, BUS_BUSY, RD_VALID}, 0);
      RST_N = 1'b1;
      repeat (6) @(negedge SYS_CLK);
      chk("rst_ready", REQ_READY, 1'b1);
      t_write();
      t_read(1'b0);
      t_read(1'b1);
      t_nack(7'h15, 8'hFF, 1'b1);
      t_nack(slv.OWN_ADDR, 8'h00, 1'b1);
      t_nack(slv.OWN_ADDR, 8'h02, 1'b0);
      t_refuse();
      t_gcall();
      t_busy();
      close_out();
   end
endmodule // two_wire_bus_protocol_engine_tb_top
